// >>> rtl/serial_eeprom_host.sv
`timescale 1ns/1ps
`include "serial_eeprom_map.svh"

module serial_eeprom_host
  import serial_eeprom_pkg::*;
(
  // Clock and reset.
  input  wire logic                     core_clk_i,
  input  wire logic                     srst_i,
  // Command port.
  input  wire logic                     cmd_valid_i,
  input  wire logic                     cmd_write_i,
  input  wire serial_eeprom_pkg::addr_t cmd_addr_i,
  input  wire serial_eeprom_pkg::len_t  cmd_len_i,
  input  wire logic                     protect_i,
  output logic                          cmd_ready_o,
  output logic                          done_o,
  // Write data, one byte per request.
  input  wire logic                     wr_valid_i,
  input  wire serial_eeprom_pkg::byte_t wr_data_i,
  output logic                          wr_req_o,
  // Read data.
  output serial_eeprom_pkg::byte_t      rd_data_o,
  output logic                          rd_valid_o,
  // Device pins.
  output logic                          cs_n_o,
  output logic                          oe_n_o,
  output logic                          we_n_o,
  output logic                          wp_n_o,
  input  wire logic                     io_i,
  output logic                          io_o,
  output logic                          io_oe_o
);
  import serial_eeprom_pkg::*;

  localparam logic [2:0] STROBE_LAST = 3'(`STROBE_LOW_CYC - 1);

  seq_state_e st_reg;
  phase_e     ph_reg;
  logic [2:0] ph_cnt_reg;
  logic       op_wr_reg;
  logic       bit_done_reg;
  logic       bit_rx_reg;
  logic [3:0] bit_cnt_reg;
  len_t       byte_cnt_reg;
  len_t       len_reg;
  logic       is_wr_reg;
  logic       byte_loaded_reg;
  logic [15:0] sh_reg;
  logic       need_op;
  logic       op_is_wr;
  logic       op_val;
  logic       bit_start;

  // ---------------------------------------------------------------------------
  // Operation selection
  // ---------------------------------------------------------------------------
  // Each step but ST_IDLE and ST_DONE names one bus cycle; write steps carry the bit they send.
  always_comb
  begin
    need_op  = 1'b0;
    op_is_wr = 1'b0;
    op_val   = 1'b0;
    case (st_reg)
      ST_RST1, ST_RST3, ST_DATA_RD, ST_NV1, ST_NV3, ST_POLL:
      begin
        need_op = 1'b1;
      end
      ST_RST2:
      begin
        need_op  = 1'b1;
        op_is_wr = 1'b1;
        op_val   = `RST_WRITE_BIT;
      end
      ST_ADDR:
      begin
        need_op  = 1'b1;
        op_is_wr = 1'b1;
        op_val   = sh_reg[15];
      end
      ST_DATA_WR:
      begin
        need_op  = byte_loaded_reg;
        op_is_wr = 1'b1;
        op_val   = sh_reg[15];
      end
      ST_END_RD:
      begin
        need_op  = 1'b1;
        op_is_wr = 1'b1;
        op_val   = `RD_END_BIT;
      end
      ST_NV2:
      begin
        need_op  = 1'b1;
        op_is_wr = 1'b1;
        op_val   = `NV_START_BIT;
      end
      default:
      begin
        need_op = 1'b0;
      end
    endcase
  end

  // The done pulse blocks a restart so the sequencer sees each result once.
  assign bit_start = (ph_reg == PH_IDLE) && need_op && !bit_done_reg;

  // ---------------------------------------------------------------------------
  // Bus cycle engine
  // ---------------------------------------------------------------------------
  // Data is set up before the strobe falls and the strobe rises one cycle
  // ahead of chip select, so the device latches on the strobe edge.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ph_reg       <= PH_IDLE;
      ph_cnt_reg   <= 3'h0;
      op_wr_reg    <= 1'b0;
      bit_done_reg <= 1'b0;
      bit_rx_reg   <= 1'b0;
      cs_n_o       <= 1'b1;
      oe_n_o       <= 1'b1;
      we_n_o       <= 1'b1;
      io_o         <= 1'b0;
      io_oe_o      <= 1'b0;
    end
    else
    begin
      bit_done_reg <= 1'b0;
      case (ph_reg)
        PH_IDLE:
        begin
          if (bit_start)
          begin
            op_wr_reg <= op_is_wr;
            cs_n_o    <= 1'b0;
            io_o      <= op_val;
            io_oe_o   <= op_is_wr;
            ph_reg    <= PH_SETUP;
          end
        end
        PH_SETUP:
        begin
          // Only one strobe ever falls per cycle.
          we_n_o     <= !op_wr_reg;
          oe_n_o     <= op_wr_reg;
          ph_cnt_reg <= STROBE_LAST;
          ph_reg     <= PH_STROBE;
        end
        PH_STROBE:
        begin
          if (ph_cnt_reg == 3'h0)
          begin
            we_n_o     <= 1'b1;
            oe_n_o     <= 1'b1;
            bit_rx_reg <= io_i;
            ph_reg     <= PH_HOLD;
          end
          else
          begin
            ph_cnt_reg <= ph_cnt_reg - 3'h1;
          end
        end
        PH_HOLD:
        begin
          cs_n_o       <= 1'b1;
          io_oe_o      <= 1'b0;
          bit_done_reg <= 1'b1;
          ph_reg       <= PH_IDLE;
        end
        default:
        begin
          ph_reg <= PH_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------------------
  // Steps wait without limit between bus cycles; the device keeps its state.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_reg          <= ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      byte_cnt_reg    <= 6'h00;
      len_reg         <= 6'h00;
      is_wr_reg       <= 1'b0;
      byte_loaded_reg <= 1'b0;
      sh_reg          <= 16'h0000;
      cmd_ready_o     <= 1'b0;
      done_o          <= 1'b0;
      wr_req_o        <= 1'b0;
      rd_data_o       <= 8'h00;
      rd_valid_o      <= 1'b0;
    end
    else
    begin
      done_o     <= 1'b0;
      rd_valid_o <= 1'b0;
      if (wr_req_o && wr_valid_i)
      begin
        sh_reg[15:8]    <= wr_data_i;
        byte_loaded_reg <= 1'b1;
        wr_req_o        <= 1'b0;
      end
      case (st_reg)
        ST_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o <= 1'b0;
            is_wr_reg   <= cmd_write_i;
            len_reg     <= cmd_len_i;
            sh_reg      <= cmd_addr_i & `ADDR_SIG_MASK;
            st_reg      <= ST_RST1;
          end
        end
        ST_RST1:
          if (bit_done_reg) st_reg <= ST_RST2;
        ST_RST2:
          if (bit_done_reg) st_reg <= ST_RST3;
        ST_RST3:
          if (bit_done_reg)
          begin
            bit_cnt_reg <= 4'h0;
            st_reg      <= ST_ADDR;
          end
        ST_ADDR:
          if (bit_done_reg)
          begin
            sh_reg      <= {sh_reg[14:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `ADDR_LAST_BIT)
            begin
              bit_cnt_reg     <= 4'h0;
              byte_cnt_reg    <= 6'h00;
              byte_loaded_reg <= 1'b0;
              wr_req_o        <= is_wr_reg;
              st_reg          <= is_wr_reg ? ST_DATA_WR : ST_DATA_RD;
            end
          end
        ST_DATA_RD:
          if (bit_done_reg)
          begin
            rd_data_o   <= {rd_data_o[6:0], bit_rx_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `BYTE_LAST_BIT)
            begin
              // The device steps its own address, so bursts just keep reading.
              rd_valid_o   <= 1'b1;
              bit_cnt_reg  <= 4'h0;
              byte_cnt_reg <= byte_cnt_reg + 6'h01;
              if (byte_cnt_reg == len_reg) st_reg <= ST_END_RD;
            end
          end
        ST_END_RD:
          if (bit_done_reg) st_reg <= ST_DONE;
        ST_DATA_WR:
          if (bit_done_reg)
          begin
            sh_reg      <= {sh_reg[14:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `BYTE_LAST_BIT)
            begin
              // A load that runs past the page end wraps inside the page in the device.
              bit_cnt_reg     <= 4'h0;
              byte_loaded_reg <= 1'b0;
              byte_cnt_reg    <= byte_cnt_reg + 6'h01;
              if (byte_cnt_reg == len_reg) st_reg <= ST_NV1;
              else wr_req_o <= 1'b1;
            end
          end
        ST_NV1:
          if (bit_done_reg) st_reg <= ST_NV2;
        ST_NV2:
          if (bit_done_reg) st_reg <= ST_NV3;
        ST_NV3, ST_POLL:
          // Low means still programming; a protected part reads high at once.
          if (bit_done_reg) st_reg <= bit_rx_reg ? ST_DONE : ST_POLL;
        ST_DONE:
        begin
          done_o <= 1'b1;
          st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Write protect pin
  // ---------------------------------------------------------------------------
  // Protection only inhibits new programming; a running one still finishes.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i) wp_n_o <= 1'b0;
    else wp_n_o <= !protect_i;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  strobe_excl_a: assert property (!(!we_n_o && !oe_n_o && !cs_n_o))
    else $error("Both strobes low under chip select.");
  strobe_select_a: assert property ((!we_n_o || !oe_n_o) |-> !cs_n_o)
    else $error("Strobe low while deselected.");
  addr_no_read_a: assert property ((st_reg == ST_ADDR) |-> oe_n_o)
    else $error("Read cycle during address load.");
  addr_length_a: assert property (
    (st_reg == ST_ADDR ##1 st_reg != ST_ADDR) |-> $past(bit_cnt_reg) == 4'hf)
    else $error("Address not sixteen bits.");
  rd_byte_a: assert property (rd_valid_o |->
    $past(st_reg) == ST_DATA_RD && $past(bit_cnt_reg) == 4'h7)
    else $error("Read byte not eight bits.");
  reset_first_a: assert property (
    (st_reg == ST_IDLE && cmd_valid_i && cmd_ready_o) |=> st_reg == ST_RST1)
    else $error("Operation not opened by reset.");
  reset_zero_a: assert property (
    (st_reg == ST_RST2 && bit_start) |=> io_oe_o && !io_o)
    else $error("Reset write not zero.");
  nv_start_a: assert property (
    (st_reg == ST_NV2 && bit_start) |=> ##1 !we_n_o && io_o && io_oe_o)
    else $error("Start-write bit not one.");
  page_whole_a: assert property (
    (st_reg == ST_DATA_WR ##1 st_reg != ST_DATA_WR) |-> $past(bit_cnt_reg) == 4'h7)
    else $error("Page data not whole bytes.");
  page_no_read_a: assert property ((st_reg == ST_DATA_WR) |-> oe_n_o)
    else $error("Read cycle during page load.");

  read_done_c: cover property (st_reg == ST_END_RD ##[1:40] done_o);
  write_done_c: cover property (st_reg == ST_POLL ##[1:40] done_o);
  seq_read_c: cover property (rd_valid_o ##[1:80] rd_valid_o);
  wr_stall_c: cover property (wr_req_o && !wr_valid_i [*3]);

endmodule

// >>> rtl/serial_eeprom_map.svh
`ifndef SERIAL_EEPROM_MAP_SVH
`define SERIAL_EEPROM_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and strobe timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ    20
`define STROBE_LOW_NS   100
`define STROBE_LOW_CYC  ((`STROBE_LOW_NS * `CLK_FREQ_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Sequence framing
// ----------------------------------------------------------------------------
`define ADDR_LAST_BIT   4'hf
`define BYTE_LAST_BIT   4'h7
`define ADDR_SIG_MASK   16'h7fff
`define RST_WRITE_BIT   1'b0
`define NV_START_BIT    1'b1
`define RD_END_BIT      1'b1

`endif

// >>> rtl/serial_eeprom_pkg.sv
package serial_eeprom_pkg;

  // Command sequence steps, one-hot.
  typedef enum logic [12:0] {
    ST_IDLE    = 13'h0001,
    ST_RST1    = 13'h0002,
    ST_RST2    = 13'h0004,
    ST_RST3    = 13'h0008,
    ST_ADDR    = 13'h0010,
    ST_DATA_RD = 13'h0020,
    ST_END_RD  = 13'h0040,
    ST_DATA_WR = 13'h0080,
    ST_NV1     = 13'h0100,
    ST_NV2     = 13'h0200,
    ST_NV3     = 13'h0400,
    ST_POLL    = 13'h0800,
    ST_DONE    = 13'h1000
  } seq_state_e;

  // Phases of one bus cycle, one-hot.
  typedef enum logic [3:0] {
    PH_IDLE   = 4'h1,
    PH_SETUP  = 4'h2,
    PH_STROBE = 4'h4,
    PH_HOLD   = 4'h8
  } phase_e;

  typedef logic [15:0] addr_t;
  typedef logic [5:0]  len_t;
  typedef logic [7:0]  byte_t;

endpackage

// >>> test/eeprom_dev_model.sv
`timescale 1ns/1ps

module eeprom_dev_model #(
  parameter int PROG_NS = 20000
) (
  // Strobes from the host.
  input  wire logic cs_n_i,
  input  wire logic oe_n_i,
  input  wire logic we_n_i,
  input  wire logic wp_n_i,
  // Data line and checks.
  input  wire logic io_i,
  output logic      io_o,
  output logic      drv_o,
  output int        viol_o
);
  // ----------------------------------------
  // Sequence state, held with no timeout.
  // ----------------------------------------
  typedef enum int {M_IDLE, M_RST, M_ADDR, M_RDY, M_RD, M_LOAD, M_CLOSE, M_NV} mode_e;
  mode_e       mode = M_IDLE;
  int          cnt, nbits, off, last = 2;
  logic [15:0] addr;
  logic [7:0]  sh, cur;
  logic        wel = 1'b0;
  logic        b;
  realtime     busy_end = 0;
  logic [7:0]  mem[int];
  logic [7:0]  pbuf[int];

  // Programming is shortened so that polling stays cheap in simulation.
  function automatic bit busy();
    return $realtime < busy_end;
  endfunction

  // Unwritten cells hold a fixed pattern.
  function automatic logic [7:0] rd_mem(int a);
    return mem.exists(a) ? mem[a] : 8'(a) ^ 8'h5a;
  endfunction

  initial
  begin
    io_o   = 1'b0;
    drv_o  = 1'b0;
    viol_o = 0;
  end

  // Read start: launch a pending program, then drive the answer.
  always @(negedge oe_n_i)
    if (!cs_n_i)
    begin
      if (!we_n_i) viol_o++;
      if (mode == M_NV)
      begin
        if (wel && wp_n_i && !busy())
        begin
          foreach (pbuf[k]) mem[int'({addr[14:6], 6'(k)})] = pbuf[k];
          busy_end = $realtime + PROG_NS;
        end
        wel  = 1'b0;
        mode = M_IDLE;
      end
      cur   = rd_mem(int'(addr[14:0]));
      drv_o = 1'b1;
      io_o  = busy() ? 1'b0 : (mode == M_RD || mode == M_RDY) ? cur[7 - cnt] : 1'b1;
    end

  // Read end: release the line to its inverse and step the sequence.
  always @(posedge oe_n_i)
    if (drv_o)
    begin
      drv_o = 1'b0;
      io_o  = ~io_o;
      case (mode)
        M_RST:   begin mode = M_ADDR; cnt = 0; end
        M_RDY:   begin mode = M_RD; cnt = 1; end
        M_RD:    begin cnt = (cnt + 1) % 8; if (cnt == 0) addr[14:0] = addr[14:0] + 15'h1; end
        M_LOAD:  begin wel = wel && nbits % 8 == 0; mode = wel ? M_CLOSE : M_IDLE; end
        default: mode = M_IDLE;
      endcase
      last = 0;
    end

  // Write end: the bit is taken as write strobe rises.
  always @(posedge we_n_i)
    if (!cs_n_i)
    begin
      b = io_i;
      if (!oe_n_i) viol_o++;
      if (mode == M_ADDR)
      begin
        addr = {addr[14:0], b};
        cnt++;
        if (cnt == 16) begin mode = M_RDY; cnt = 0; nbits = 0; off = addr[5:0]; pbuf.delete(); end
      end
      else if (!b && last == 0) begin mode = M_RST; cnt = 0; wel = 1'b1; end
      else if (mode == M_RDY || mode == M_LOAD)
      begin
        mode = M_LOAD;
        sh   = {sh[6:0], b};
        nbits++;
        if (nbits % 8 == 0) begin pbuf[off] = sh; off = (off + 1) % 64; end
      end
      else if (mode == M_CLOSE && b) mode = M_NV;
      else begin mode = M_IDLE; wel = 1'b0; end
      last = b ? 2 : 1;
    end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps

module testbench;
  import serial_eeprom_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  logic  core_clk_i, srst_i, cmd_valid_i, cmd_write_i, protect_i, wr_valid_i;
  addr_t cmd_addr_i;
  len_t  cmd_len_i;
  byte_t wr_data_i, rd_data_o, e;
  logic  cmd_ready_o, done_o, wr_req_o, rd_valid_o, cs_n_o, oe_n_o, we_n_o, wp_n_o;
  logic  io_i, io_o, io_oe_o, dev_io, dev_drv;
  int    errors, n_compared, viol;
  byte_t ref_mem[int];
  byte_t exp_q[$];
  byte_t wq[$];
  bit    stall;

  assign io_i = io_oe_o ? io_o : dev_io;

  serial_eeprom_host uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
    .protect_i(protect_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .wr_req_o(wr_req_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .cs_n_o(cs_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .wp_n_o(wp_n_o), .io_i(io_i),
    .io_o(io_o), .io_oe_o(io_oe_o));

  eeprom_dev_model #(.PROG_NS(20000)) dev (.cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .wp_n_i(wp_n_o), .io_i(io_i), .io_o(dev_io), .drv_o(dev_drv), .viol_o(viol));

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic byte_t ref_rd(int a);
    return ref_mem.exists(a) ? ref_mem[a] : 8'(a) ^ 8'h5a;
  endfunction

  // Bytes are checked as they arrive; write bytes leave the queue when taken.
  always @(posedge core_clk_i)
  begin
    if (rd_valid_o === 1'b1)
    begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
      `CHK("rd_data", e, rd_data_o)
    end
    if (dev_drv === 1'b1) `CHK("io_contention", 1'b0, io_oe_o)
    if (wr_req_o === 1'b1 && wr_valid_i) void'(wq.pop_front());
  end

  // Write data source, stalling at random when asked to.
  always @(negedge core_clk_i)
  begin
    wr_valid_i <= wq.size() != 0 && (!stall || $urandom_range(3) == 0);
    wr_data_i  <= (wq.size() != 0) ? wq[0] : 8'h00;
  end

  // One command from take to done, with its expectations.
  task automatic run_cmd(input bit wr, input addr_t a, input int n, input bit prot);
    byte_t d;
    @(negedge core_clk_i);
    {cmd_write_i, cmd_addr_i, cmd_len_i, protect_i} = {wr, a, len_t'(n - 1), prot};
    cmd_valid_i = 1'b1;
    for (int k = 0; k < n; k++)
    begin
      d = byte_t'($urandom);
      if (!wr) exp_q.push_back(ref_rd(int'((a + 16'(k)) & 16'h7fff)));
      else wq.push_back(d);
      if (wr && !prot) ref_mem[int'({a[14:6], 6'(a[5:0] + 6'(k))})] = d;
    end
    do @(posedge core_clk_i); while (cmd_ready_o !== 1'b1);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    do @(posedge core_clk_i); while (done_o !== 1'b1);
    `CHK("bytes_left", 0, exp_q.size() + wq.size())
    `CHK("wp_pin", !prot, wp_n_o)
  endtask

  task automatic results();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reads, a wrapping write, a stalled full page, a protected write, random reads.
  initial
  begin
    {errors, n_compared, stall} = '0;
    {srst_i, cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_len_i} = {1'b1, 24'h0};
    protect_i = 1'b0;
    void'($urandom(32'hc4c4));
    repeat (6) @(negedge core_clk_i);
    srst_i = 1'b0;
    `CHK("wp_reset", 1'b0, wp_n_o)
    run_cmd(1'b0, 16'h8123, 4, 1'b0);
    run_cmd(1'b0, 16'h7ffe, 3, 1'b0);
    run_cmd(1'b1, 16'h00bc, 8, 1'b0);
    stall = 1'b1;
    run_cmd(1'b1, 16'h0100, 64, 1'b0);
    stall = 1'b0;
    run_cmd(1'b0, 16'h0080, 64, 1'b0);
    run_cmd(1'b1, 16'h0100, 3, 1'b1);
    run_cmd(1'b0, 16'h0100, 64, 1'b0);
    for (int i = 0; i < 3; i++)
      run_cmd(1'b0, addr_t'($urandom), $urandom_range(8, 1), 1'b0);
    // A reset in mid address load idles the pins at once; a fresh command recovers.
    @(negedge core_clk_i);
    {cmd_write_i, cmd_addr_i, cmd_len_i, protect_i} = {1'b0, 16'h0200, 6'h00, 1'b0};
    cmd_valid_i = 1'b1;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    repeat (60) @(negedge core_clk_i);
    srst_i = 1'b1;
    @(negedge core_clk_i);
    `CHK("rst_pins", 6'b111000, {cs_n_o, oe_n_o, we_n_o, io_oe_o, cmd_ready_o, wp_n_o})
    repeat (5) @(negedge core_clk_i);
    srst_i = 1'b0;
    run_cmd(1'b0, 16'h0200, 2, 1'b0);
    `CHK("strobe_overlap", 0, viol)
    results();
  end

  // Hang guard, about four and a half times the expected run.
  initial
  begin
    #3000000;
    errors++;
    results();
  end
endmodule
